// ### dv/lfp_dev_model.sv
// Behavioural model of the fusible logic array as seen from its pins.
// Assumes pin levels arrive as the programmer's level-select codes.
`timescale 1ns/1ps
`default_nettype none
`include "lfp_defs.vh"
module lfp_dev_model
(
   input wire logic i_clk_sys,
   input wire logic [1:0] i_vcc_sel,
   input wire logic i_fe,
   input wire logic i_cs_n,
   input wire logic i_cs_hv,
   input wire logic [15:0] i_level,
   input wire logic [15:0] i_dis,
   input wire logic [7:0] i_drv,
   input wire logic [7:0] i_oe_n,
   input wire logic [7:0] i_hv,
   output logic [7:0] o_pin
);
   logic [7:0] pol_low_q = 8'h00;
   logic [7:0] sum_cut_q [0:47];
   logic [15:0] t_cut_q [0:47];
   logic [15:0] c_cut_q [0:47];
   logic [15:0] hv_cnt_q = 16'h0000;
   logic [7:0] hv_q = 8'h00;
   logic cs_hv_q = 1'b0;
   logic tgl_q = 1'b0;
   logic [7:0] drv;
   logic sense;
   // Blank part: every link intact
   initial
   begin
      for (int k = 0; k < 48; k = k + 1)
      begin
         sum_cut_q[k] = 8'h00;
         t_cut_q[k] = 16'h0000;
         c_cut_q[k] = 16'h0000;
      end
   end
   // Fuse events, judged when the high voltage is taken away
   always @(posedge i_clk_sys)
   begin
      tgl_q <= ~tgl_q;
      cs_hv_q <= i_cs_hv;
      hv_q <= i_hv;
      hv_cnt_q <= (i_vcc_sel == `LFP_VCC_OFF && i_hv != 8'h00) ? hv_cnt_q + 16'h0001 : 16'h0000;
      if (i_hv == 8'h00 && hv_q != 8'h00 && hv_cnt_q >= `LFP_PULSE_CYC)
         pol_low_q <= pol_low_q | hv_q;
      if (cs_hv_q && !i_cs_hv && i_fe)
      begin
         if (i_vcc_sel == `LFP_VCC_HI)
            sum_cut_q[i_level[5:0]] <= sum_cut_q[i_level[5:0]] | i_hv;
         else
            for (int j = 0; j < 16; j = j + 1)
               if (!i_dis[j] && i_level[j])
                  c_cut_q[i_drv[5:0]][j] <= 1'b1;
               else if (!i_dis[j])
                  t_cut_q[i_drv[5:0]][j] <= 1'b1;
      end
   end
   // Output pins; undriven pins show a changing pattern except in the polarity and sum reads, and pin 7 in the input-link read
   always @*
   begin
      drv = {4{tgl_q, ~tgl_q}};
      sense = tgl_q;
      for (int j = 0; j < 16; j = j + 1)
         if (!i_dis[j])
            sense = i_level[j] ? t_cut_q[i_drv[5:0]][j] : ~c_cut_q[i_drv[5:0]][j];
      if (i_vcc_sel == `LFP_VCC_NOM && !i_cs_n && (&i_dis))
         drv = ~pol_low_q;
      else if (i_vcc_sel == `LFP_VCC_NOM && !i_cs_n)
         drv = pol_low_q;
      else if (i_vcc_sel == `LFP_VCC_NOM && i_cs_hv && !i_fe)
         drv[7] = sense;
      else if (i_vcc_sel == `LFP_VCC_HI && !i_cs_n)
         drv = ~sum_cut_q[i_level[5:0]] ^ pol_low_q;
      for (int j = 0; j < 8; j = j + 1)
         o_pin[j] = i_oe_n[j] ? drv[j] : i_drv[j];
   end
endmodule // lfp_dev_model
`default_nettype wire

// ### dv/lfp_prog_bench.sv
// Self-checking bench: programmer against the array model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`default_nettype none
`include "lfp_defs.vh"
module lfp_prog_bench;
   logic i_clk_sys = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_start = 1'b0;
   logic [2:0] i_op = 3'h0;
   logic [5:0] i_term = 6'h00;
   logic [3:0] i_in_sel = 4'h0;
   logic [2:0] i_out_sel = 3'h0;
   logic [1:0] i_lit = 2'h1;
   logic i_exclude = 1'b0;
   logic o_busy, o_done, o_err, o_fe, o_cs_n, o_cs_hv;
   logic [1:0] o_vcc_sel;
   logic [7:0] o_result, o_out_drv, o_out_oe_n, o_out_hv, i_out_pin;
   logic [15:0] o_logic_input, o_in_dis;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   lfp_prog dut_u (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_start(i_start), .i_op(i_op),
      .i_term(i_term), .i_in_sel(i_in_sel), .i_out_sel(i_out_sel), .i_lit(i_lit),
      .i_exclude(i_exclude), .o_busy(o_busy), .o_done(o_done), .o_err(o_err),
      .o_result(o_result), .o_vcc_sel(o_vcc_sel), .o_fuse_voltage_pin(o_fe), .o_cs_n(o_cs_n),
      .o_cs_hv(o_cs_hv), .o_logic_input(o_logic_input), .o_in_dis(o_in_dis),
      .o_out_drv(o_out_drv), .o_out_oe_n(o_out_oe_n), .o_out_hv(o_out_hv),
      .i_out_pin(i_out_pin));
   lfp_dev_model dev_u (.i_clk_sys(i_clk_sys), .i_vcc_sel(o_vcc_sel), .i_fe(o_fe),
      .i_cs_n(o_cs_n), .i_cs_hv(o_cs_hv), .i_level(o_logic_input), .i_dis(o_in_dis),
      .i_drv(o_out_drv), .i_oe_n(o_out_oe_n), .i_hv(o_out_hv), .o_pin(i_out_pin));
   // Clock and hang guard; two 1 ms fuse pulses dominate the run
   initial
   begin
      forever #10 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys)
   begin
      cycles = cycles + 1;
      if (cycles == 115000)
      begin
         bad_count = bad_count + 1;
         $display("unexpected at %0t: run too long", $time);
         final_report();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares = compares + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // One command, held steady until done; done is seen at a falling edge
   task automatic run(input logic [2:0] op, input logic [5:0] term, input logic [3:0] isel,
      input logic [2:0] osel, input logic excl, input logic err_exp);
      int n;
      @(negedge i_clk_sys);
      i_op = op;
      i_term = term;
      i_in_sel = isel;
      i_out_sel = osel;
      i_exclude = excl;
      i_start = 1'b1;
      @(negedge i_clk_sys);
      i_start = 1'b0;
      n = 0;
      while (o_done !== 1'b1 && n < 60000)
      begin
         @(negedge i_clk_sys);
         n = n + 1;
      end
      check({7'h00, o_done}, 8'h01, "done");
      check({7'h00, o_err}, {7'h00, err_exp}, "error flag");
   endtask
   task automatic t_reset;
      check({o_busy, o_done, o_err, o_cs_n, o_vcc_sel, o_fe, o_cs_hv}, 8'h10, "reset pins");
      check(o_out_oe_n, 8'hFF, "reset output enables");
   endtask
   task automatic t_pol_fuse;
      run(`LFP_OP_POLV, 6'h00, 4'h0, 3'h0, 1'b0, 1'b0);
      check(o_result, 8'hFF, "blank polarity");
      run(`LFP_OP_POL, 6'h00, 4'h0, 3'h2, 1'b0, 1'b0);
      run(`LFP_OP_POLV, 6'h00, 4'h0, 3'h0, 1'b0, 1'b0);
      check(o_result, 8'hFB, "output 2 active low");
   endtask
   task automatic t_prod_verify;
      run(`LFP_OP_PRODV, `LFP_LAST_TERM, 4'hF, 3'h0, 1'b0, 1'b0);
      check({6'h00, o_result[1:0]}, 8'h01, "blank input link");
   endtask
   // Complement link only on input 15 of term 47, then read it back
   task automatic t_prod_fuse;
      i_lit = 2'h3;
      run(`LFP_OP_PROD, `LFP_LAST_TERM, 4'hF, 3'h0, 1'b0, 1'b0);
      run(`LFP_OP_PRODV, `LFP_LAST_TERM, 4'hF, 3'h0, 1'b0, 1'b0);
      check({6'h00, o_result[1:0]}, 8'h00, "complement link fused");
   endtask
   task automatic t_sum;
      run(`LFP_OP_SUM, 6'h05, 4'h0, 3'h3, 1'b0, 1'b0);
      run(`LFP_OP_SUMV, 6'h05, 4'h0, 3'h0, 1'b0, 1'b0);
      check(o_result, 8'hFB, "term 5 links present");
      run(`LFP_OP_SUMV, 6'h30, 4'h0, 3'h0, 1'b0, 1'b1);
   endtask
   task automatic final_report;
      $display("mismatches %0d, compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Main sequence: the refusal must come before any polarity pass
   initial
   begin
      repeat (5) @(negedge i_clk_sys);
      t_reset();
      repeat (5) @(negedge i_clk_sys);
      i_arst_n = 1'b1;
      repeat (4) @(negedge i_clk_sys);
      run(`LFP_OP_SUM, 6'h00, 4'h0, 3'h3, 1'b1, 1'b1);
      run(`LFP_OP_PROD, 6'h00, 4'h0, 3'h0, 1'b0, 1'b1);
      t_pol_fuse();
      t_prod_verify();
      t_prod_fuse();
      t_sum();
      final_report();
   end
endmodule // lfp_prog_bench
`default_nettype wire

// ### dv/lfp_prog_properties.sv
// Concurrent checks on the fuse programmer pin sequencing.
// Assumes it is bound to lfp_prog and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "lfp_defs.vh"
module lfp_prog_chk
(
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_start,
   input wire logic [2:0] i_op,
   input wire logic [5:0] i_term,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic o_err,
   input wire logic [1:0] o_vcc_sel,
   input wire logic o_fuse_voltage_pin,
   input wire logic o_cs_n,
   input wire logic o_cs_hv,
   input wire logic [15:0] o_in_dis,
   input wire logic [7:0] o_out_oe_n,
   input wire logic [7:0] o_out_hv
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);
   logic [15:0] hv_cnt_q;
   // Select pulse length; cleared between pulses so each is timed alone
   always @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         hv_cnt_q <= 16'h0000;
      else
         hv_cnt_q <= o_cs_hv ? hv_cnt_q + 16'h0001 : 16'h0000;
   end
   // Verify of input links also raises select, so it is left out here
   a_pulse_under_fe: assert property ((o_cs_hv && i_op != `LFP_OP_PRODV) |-> o_fuse_voltage_pin)
      else $error("select pulse without fuse voltage");
   a_pulse_length: assert property (($fell(o_cs_hv) && i_op != `LFP_OP_PRODV) |-> hv_cnt_q == `LFP_PULSE_CYC)
      else $error("select pulse not 1 ms");
   a_fe_lead: assert property (($rose(o_cs_hv) && i_op != `LFP_OP_PRODV) |-> $past(o_fuse_voltage_pin, 490))
      else $error("fuse voltage not settled before pulse");
   a_fe_trail: assert property (($fell(o_cs_hv) && i_op != `LFP_OP_PRODV) |-> o_fuse_voltage_pin [*8])
      else $error("fuse voltage dropped with pulse");
   a_one_output: assert property ((o_out_hv != 8'h00) |-> $onehot(o_out_hv))
      else $error("more than one output at high voltage");
   a_pol_unpowered: assert property ((o_out_hv != 8'h00 && i_op == `LFP_OP_POL) |-> (o_vcc_sel == `LFP_VCC_OFF && !o_fuse_voltage_pin))
      else $error("polarity fuse with supply on");
   a_sum_setup: assert property ((o_fuse_voltage_pin && i_op == `LFP_OP_SUM) |-> (o_vcc_sel == `LFP_VCC_HI && o_cs_n))
      else $error("sum fuse setup wrong");
   a_prod_setup: assert property ((o_fuse_voltage_pin && i_op == `LFP_OP_PROD) |-> (o_cs_n && o_out_oe_n[5:0] == 6'h00 && $onehot(~o_in_dis)))
      else $error("product fuse setup wrong");
   a_pol_verify: assert property ((o_busy && i_op == `LFP_OP_POLV && !o_cs_n) |-> (o_in_dis == 16'hFFFF && o_vcc_sel == `LFP_VCC_NOM))
      else $error("polarity verify setup wrong");
   a_bad_term: assert property ((i_start && !o_busy && !o_done && i_op == `LFP_OP_SUMV && i_term > `LFP_LAST_TERM) |-> ##[1:2] (o_done && o_err))
      else $error("term out of range not refused");
   a_idle_on_done: assert property (o_done |-> (!o_fuse_voltage_pin && !o_cs_hv && o_out_hv == 8'h00))
      else $error("pins not idle at done");
endmodule // lfp_prog_chk
bind lfp_prog lfp_prog_chk chk_u (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_start(i_start),
   .i_op(i_op), .i_term(i_term), .o_busy(o_busy), .o_done(o_done), .o_err(o_err),
   .o_vcc_sel(o_vcc_sel), .o_fuse_voltage_pin(o_fuse_voltage_pin), .o_cs_n(o_cs_n),
   .o_cs_hv(o_cs_hv), .o_in_dis(o_in_dis), .o_out_oe_n(o_out_oe_n), .o_out_hv(o_out_hv));
`default_nettype wire

// ### hw/lfp_defs.vh
// Constants for the logic array fuse programmer: pin codes, timing, counts.
// Assumes a 50 MHz system clock and external level shifters driven by the
// level-select codes below.
// Functional notes
// - Polarity first, one output per pass
// - Active-low: supply off, output high 1 ms
// - One input, one term at a time
// - Term code on outputs 0-5, chip off
// - High fuses complement, low fuses true
// - Fuse: enable up, select pulse, enable down
// - Restore input; walk inputs, terms; release
// - Verify input link: sense high and low
// - Sum: supply elevated, term on inputs 0-5
// - One output per term in sum
// - Exclude term: fuse output; include: skip
`ifndef LFP_DEFS_VH
`define LFP_DEFS_VH
// ----------------------------------------------------------------------
// Array shape
// ----------------------------------------------------------------------
`define LFP_N_IN 16
`define LFP_N_OUT 8
`define LFP_N_TERM 48
`define LFP_LAST_TERM 6'h2F
// ----------------------------------------------------------------------
// Operation codes on i_op
// ----------------------------------------------------------------------
`define LFP_OP_POL 3'h0
`define LFP_OP_POLV 3'h1
`define LFP_OP_PROD 3'h2
`define LFP_OP_PRODV 3'h3
`define LFP_OP_SUM 3'h4
`define LFP_OP_SUMV 3'h5
// ----------------------------------------------------------------------
// Supply level codes on o_vcc_sel
// ----------------------------------------------------------------------
`define LFP_VCC_OFF 2'h0
`define LFP_VCC_NOM 2'h1
`define LFP_VCC_HI 2'h2
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LFP_CLK_MHZ 50
`define LFP_STEP_US 10
`define LFP_PULSE_US 1000
// Counts are sized so they meet the 16-bit timer with no truncation
`define LFP_STEP_CYC 16'h01F4
`define LFP_PULSE_CYC 16'hC350
`define LFP_TMR_LAT 16'h0002
`define LFP_CNT_W 16
`endif

// ### hw/lfp_prog.v
// Fuse programmer sequencer for a 16x48x8 logic array.
// Assumes external shifters turn the level outputs into fusing voltages,
// and that the sensed outputs come back as plain logic levels.
`timescale 1ns/1ps
`default_nettype none
`include "lfp_defs.vh"
module lfp_prog
(
   input wire i_clk_sys,
   input wire i_arst_n,
   // Command
   input wire i_start,
   input wire [2:0] i_op,
   input wire [5:0] i_term,
   input wire [3:0] i_in_sel,
   input wire [2:0] i_out_sel,
   input wire [1:0] i_lit,
   input wire i_exclude,
   output reg o_busy,
   output reg o_done,
   output reg o_err,
   output reg [7:0] o_result,
   // Device pins
   output reg [1:0] o_vcc_sel,
   output reg o_fuse_voltage_pin,
   output reg o_cs_n,
   output reg o_cs_hv,
   output reg [15:0] o_logic_input,
   output reg [15:0] o_in_dis,
   output reg [7:0] o_out_drv,
   output reg [7:0] o_out_oe_n,
   output reg [7:0] o_out_hv,
   input wire [7:0] i_out_pin
);
   // ---------------------------------------------------------------
   // Reset release and pin synchronisation
   // ---------------------------------------------------------------
   reg rst_m_q;
   reg rst_q;
   wire rst_n = rst_q;
   wire [7:0] sense;
   always @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_m_q <= 1'b0;
         rst_q <= 1'b0;
      end
      else
      begin
         rst_m_q <= 1'b1;
         rst_q <= rst_m_q;
      end
   end
   lfp_sync2 #(.W(8)) u_sync
   (
      .i_clk(i_clk_sys),
      .i_rst_n(rst_n),
      .i_d(i_out_pin),
      .o_q(sense)
   );
   // ---------------------------------------------------------------
   // States and wait timer
   // ---------------------------------------------------------------
   localparam S_IDLE = 4'h0;
   localparam S_SETUP = 4'h1;
   localparam S_POLHV = 4'h2;
   localparam S_FEUP = 4'h3;
   localparam S_CSHV = 4'h4;
   localparam S_FEDN = 4'h5;
   localparam S_REST = 4'h6;
   localparam S_SENSE = 4'h7;
   localparam S_SENSE2 = 4'h8;
   localparam S_END = 4'h9;
   reg [3:0] st_q;
   reg [1:0] pass_q;
   reg pol_done_q;
   reg tload;
   reg [`LFP_CNT_W-1:0] tcount;
   wire tdone;
   lfp_timer u_tmr
   (
      .i_clk(i_clk_sys),
      .i_rst_n(rst_n),
      .i_load(tload),
      .i_count(tcount),
      .o_done(tdone)
   );
   // Literal: 01 fuse complement, 10 fuse true, 00 fuse both, 11 complement only
   wire fuse_comp = (i_lit != 2'b10);
   wire fuse_true = ~i_lit[0];
   wire is_prog = (i_op == `LFP_OP_POL) | (i_op == `LFP_OP_PROD) |
      (i_op == `LFP_OP_SUM);
   // ---------------------------------------------------------------
   // Sequencer: at most one fuse or one verify per command, two fuses for a product with both links
   // ---------------------------------------------------------------
   always @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= S_IDLE;
         pass_q <= 2'h0;
         pol_done_q <= 1'b0;
         tload <= 1'b0;
         tcount <= {`LFP_CNT_W{1'b0}};
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_err <= 1'b0;
         o_result <= 8'h00;
         o_vcc_sel <= `LFP_VCC_OFF;
         o_fuse_voltage_pin <= 1'b0;
         o_cs_n <= 1'b1;
         o_cs_hv <= 1'b0;
         o_logic_input <= 16'h0000;
         o_in_dis <= 16'h0000;
         o_out_drv <= 8'h00;
         o_out_oe_n <= 8'hFF;
         o_out_hv <= 8'h00;
      end
      else
      begin
         tload <= 1'b0;
         o_done <= 1'b0;
         case (st_q)
            S_IDLE:
            begin
               if (i_start)
               begin
                  o_err <= 1'b0;
                  // Polarity must precede any matrix fusing
                  if (((i_op == `LFP_OP_PROD) | (i_op == `LFP_OP_SUM)) & ~pol_done_q)
                  begin
                     o_err <= 1'b1;
                     o_done <= 1'b1;
                  end
                  else if (i_term > `LFP_LAST_TERM || i_op > `LFP_OP_SUMV)
                  begin
                     o_err <= 1'b1;
                     o_done <= 1'b1;
                  end
                  else
                  begin
                     o_busy <= 1'b1;
                     pass_q <= 2'h0;
                     st_q <= S_SETUP;
                     tload <= 1'b1;
                     tcount <= `LFP_STEP_CYC;
                     case (i_op)
                        `LFP_OP_POL:
                        begin
                           o_vcc_sel <= `LFP_VCC_OFF;
                        end
                        `LFP_OP_POLV:
                        begin
                           o_vcc_sel <= `LFP_VCC_NOM;
                           o_cs_n <= 1'b0;
                           o_in_dis <= 16'hFFFF;
                        end
                        `LFP_OP_PROD, `LFP_OP_PRODV:
                        begin
                           o_vcc_sel <= `LFP_VCC_NOM;
                           // Select stays high; verify lifts it to high voltage
                           o_cs_n <= 1'b1;
                           o_cs_hv <= (i_op == `LFP_OP_PRODV);
                           o_in_dis <= 16'hFFFF;
                           o_out_drv <= {2'b00, i_term};
                           o_out_oe_n <= 8'hC0;
                        end
                        default:
                        begin
                           o_vcc_sel <= `LFP_VCC_HI;
                           o_cs_n <= (i_op == `LFP_OP_SUM);
                           o_logic_input <= {10'h000, i_term};
                        end
                     endcase
                  end
               end
            end
            S_SETUP:
            begin
               if (tdone)
               begin
                  tload <= 1'b1;
                  tcount <= `LFP_STEP_CYC;
                  case (i_op)
                     `LFP_OP_POL:
                     begin
                        o_out_hv[i_out_sel] <= 1'b1;
                        tcount <= `LFP_PULSE_CYC;
                        st_q <= S_POLHV;
                     end
                     `LFP_OP_PROD:
                     begin
                        // Pass 0 fuses the complement link, pass 1 the true link
                        if (pass_q == 2'h0 && fuse_comp)
                        begin
                           o_in_dis[i_in_sel] <= 1'b0;
                           o_logic_input[i_in_sel] <= 1'b1;
                           st_q <= S_FEUP;
                        end
                        else if (pass_q != 2'h2 && fuse_true)
                        begin
                           pass_q <= 2'h1;
                           o_in_dis[i_in_sel] <= 1'b0;
                           o_logic_input[i_in_sel] <= 1'b0;
                           st_q <= S_FEUP;
                        end
                        else
                           st_q <= S_END;
                     end
                     `LFP_OP_SUM:
                     begin
                        if (i_exclude)
                        begin
                           o_out_hv[i_out_sel] <= 1'b1;
                           st_q <= S_FEUP;
                        end
                        else
                           st_q <= S_END;
                     end
                     `LFP_OP_PRODV:
                     begin
                        o_in_dis[i_in_sel] <= 1'b0;
                        o_logic_input[i_in_sel] <= 1'b1;
                        st_q <= S_SENSE;
                     end
                     default:
                        st_q <= S_SENSE;
                  endcase
               end
            end
            S_POLHV:
            begin
               if (tdone)
               begin
                  o_out_hv <= 8'h00;
                  pol_done_q <= 1'b1;
                  st_q <= S_END;
               end
            end
            S_FEUP:
            begin
               if (tdone)
               begin
                  o_fuse_voltage_pin <= 1'b1;
                  tload <= 1'b1;
                  tcount <= `LFP_STEP_CYC;
                  st_q <= S_CSHV;
               end
            end
            S_CSHV:
            begin
               if (tdone && !o_cs_hv)
               begin
                  o_cs_hv <= 1'b1;
                  tload <= 1'b1;
                  tcount <= `LFP_PULSE_CYC;
               end
               else if (tdone)
               begin
                  o_cs_hv <= 1'b0;
                  tload <= 1'b1;
                  tcount <= `LFP_STEP_CYC;
                  st_q <= S_FEDN;
               end
            end
            S_FEDN:
            begin
               if (tdone)
               begin
                  o_fuse_voltage_pin <= 1'b0;
                  tload <= 1'b1;
                  tcount <= `LFP_STEP_CYC;
                  st_q <= S_REST;
               end
            end
            S_REST:
            begin
               if (tdone)
               begin
                  o_in_dis[i_in_sel] <= (i_op == `LFP_OP_PROD);
                  o_out_hv <= 8'h00;
                  if (i_op == `LFP_OP_PROD && pass_q == 2'h0 && fuse_true)
                  begin
                     pass_q <= 2'h1;
                     tload <= 1'b1;
                     tcount <= `LFP_STEP_CYC;
                     st_q <= S_SETUP;
                  end
                  else
                  begin
                     pass_q <= 2'h2;
                     st_q <= S_END;
                  end
               end
            end
            S_SENSE:
            begin
               if (tdone)
               begin
                  if (i_op == `LFP_OP_PRODV)
                  begin
                     o_result[1] <= sense[7];
                     o_logic_input[i_in_sel] <= 1'b0;
                     tload <= 1'b1;
                     tcount <= `LFP_STEP_CYC;
                     st_q <= S_SENSE2;
                  end
                  else
                  begin
                     o_result <= sense;
                     st_q <= S_END;
                  end
               end
            end
            S_SENSE2:
            begin
               if (tdone)
               begin
                  o_result[0] <= sense[7];
                  st_q <= S_END;
               end
            end
            S_END:
            begin
               // Release every pin to its idle level
               o_busy <= 1'b0;
               o_done <= 1'b1;
               o_vcc_sel <= `LFP_VCC_OFF;
               o_fuse_voltage_pin <= 1'b0;
               o_cs_n <= 1'b1;
               o_cs_hv <= 1'b0;
               o_logic_input <= 16'h0000;
               o_in_dis <= 16'h0000;
               o_out_drv <= 8'h00;
               o_out_oe_n <= 8'hFF;
               o_out_hv <= 8'h00;
               st_q <= S_IDLE;
            end
            default:
               st_q <= S_IDLE;
         endcase
      end
   end
endmodule // lfp_prog
`default_nettype wire

// ### hw/lfp_sync2.v
// Two-stage synchroniser for pin inputs.
// Assumes destination clock i_clk; input may change at any time.
`timescale 1ns/1ps
`default_nettype none
module lfp_sync2 #(parameter W = 1)
(
   input wire i_clk,
   input wire i_rst_n,
   input wire [W-1:0] i_d,
   output wire [W-1:0] o_q
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   // First stage feeds only the second
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else
      begin
         meta_q <= i_d;
         sync_q <= meta_q;
      end
   end
   assign o_q = sync_q;
endmodule // lfp_sync2
`default_nettype wire

// ### hw/lfp_timer.v
// Wait timer: load a cycle count, pulses done when it runs out.
// Assumes i_load is a one-cycle pulse from the sequencer, and that the
// sequencer reacts to o_done on the next edge.
`timescale 1ns/1ps
`default_nettype none
`include "lfp_defs.vh"
module lfp_timer
(
   input wire i_clk,
   input wire i_rst_n,
   input wire i_load,
   input wire [`LFP_CNT_W-1:0] i_count,
   output wire o_done
);
   reg [`LFP_CNT_W-1:0] cnt_q;
   reg run_q;
   reg done_q;
   // Down counter; a load during a run restarts it
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_q <= {`LFP_CNT_W{1'b0}};
         run_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (i_load)
         begin
            // Load and done registers add two cycles; take them off so waits are exact
            cnt_q <= i_count - `LFP_TMR_LAT;
            run_q <= 1'b1;
         end
         else if (run_q)
         begin
            if (cnt_q <= 16'h0001)
            begin
               run_q <= 1'b0;
               done_q <= 1'b1;
            end
            else
               cnt_q <= cnt_q - 16'h0001;
         end
      end
   end
   assign o_done = done_q;
endmodule // lfp_timer
`default_nettype wire
